// [rsc_pkg.sv]
`default_nettype none
// ***************************************************************
// reset source capture constants and types
// ***************************************************************
package rsc_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_STAB_NS = 10000;
  localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_RST_NS = 500;
  localparam int INT_RST_CYCLES = (INT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  localparam int WDT_W = 16;
  localparam int ADDR_W = 12;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [11:0] OFS_CAUSE = 12'h000;
  localparam logic [11:0] OFS_KEY = 12'h004;
  localparam logic [11:0] OFS_BITOP = 12'h008;
  localparam logic [11:0] OFS_CLKCTL = 12'h00C;
  localparam logic [11:0] OFS_DBG = 12'h010;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFS_STATUS = 12'h01C;

  localparam logic [7:0] PROTECT_KEY = 8'hA5;
  localparam int WDT_FLAG_BIT = 4;
  localparam int CLM_FLAG_BIT = 1;
  localparam int LVD_FLAG_BIT = 0;
  localparam int BITOP_VAL_BIT = 8;
  localparam logic [7:0] CAUSE_MASK = 8'h13;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] DBG_RESET = 8'h01;
  localparam logic [7:0] DBG_MASK = 8'h01;
  localparam logic [2:0] CPU_DIV8 = 3'h3;

  localparam int IRQ_W = 4;
  localparam int IRQ_WDT = 0;
  localparam int IRQ_CLM = 1;
  localparam int IRQ_LVD = 2;
  localparam int IRQ_PROT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_INT_RST = 2'b00,
    ST_STAB = 2'b01,
    ST_RUN = 2'b10
  } rsc_state_t;

  typedef struct packed {
    logic wdt;
    logic clock_monitor;
    logic lvd;
  } rsc_reset_req_t;

  typedef struct packed {
    logic main_en;
    logic int_en;
    logic sub_en;
  } rsc_osc_ctrl_t;

endpackage : rsc_pkg
`default_nettype wire

// [rsc_src_model.sv]
`default_nettype none
// ***************************************************************
// stand-in for the internal reset sources and internal oscillator
// ***************************************************************
module rsc_src_model
  import rsc_pkg::*;
#(
  parameter int REQ_LEN = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire rsc_reset_req_t fire,
  input wire rsc_reset_req_t stretch,
  input wire rsc_osc_ctrl_t osc_ctrl,
  output rsc_reset_req_t reset_req,
  output logic int_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  rsc_reset_req_t req_ff;
  logic [7:0] len_ff;
  logic [1:0] div_ff;
  logic [7:0] nxt_len;
  wire logic fired = |fire;
  assign nxt_len = fired ? 8'(REQ_LEN) : (len_ff != 8'h00 ? len_ff - 8'h01 : 8'h00);
  // a held stretch models a slow source that keeps asserting
  assign reset_req = req_ff | stretch;
  // oscillator stands still while its enable is low, no free-running tick
  assign int_osc_tick = div_ff[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= '0;
      len_ff <= 8'h00;
      div_ff <= 2'h0;
    end else begin
      req_ff <= fired ? fire : (nxt_len == 8'h00 ? '0 : req_ff);
      len_ff <= nxt_len;
      div_ff <= osc_ctrl.int_en ? div_ff + 2'h1 : 2'h0;
    end
  end
endmodule : rsc_src_model
`default_nettype wire

// [rsc_top.sv]
`default_nettype none
//Behaviour
// RULE_01 - pin reset clears the whole cause register to zero
// RULE_02 - cause register changes only after the protect key write, never by plain store
// RULE_03 - cause register accepts whole byte writes and single bit operations
// RULE_04 - bit 4 flags a watchdog reset since last clear
// RULE_05 - bit 1 flags a clock monitor reset since last clear
// RULE_06 - bit 0 flags a low voltage reset; bits 7:5, 3, 2 read zero
// RULE_07 - an internal reset sets only its own flag, others kept
// RULE_08 - software can only clear flags; writing one does nothing
// RULE_09 - flag set wins over a coinciding software clear
// RULE_10 - while the pin is low the whole system stays in reset
// RULE_11 - reset is released on the low to high edge of the pin
// RULE_12 - pin reset initialises registers and loads debug control with 01H
// RULE_13 - clocks start after stabilisation with cpu divider at divide by eight
// RULE_14 - watchdog counter cleared in reset, counts up on internal oscillator after
// RULE_15 - cpu held in reset, fetch only after stabilisation wait
// RULE_16 - peripherals stopped in reset, startable only after stabilisation wait
// RULE_17 - ram kept across reset except power-on or access colliding with reset
// RULE_18 - debug enable set plus high debug reset pin enters debug mode
// RULE_19 - main and internal oscillators stop in reset, subclock runs, restart on release
module rsc_top
  import rsc_pkg::*;
#(
  parameter int STAB_CYCLES = OSC_STAB_CYCLES,
  parameter int HOLD_CYCLES = INT_RST_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rsc_reset_req_t reset_req,
  input wire logic int_osc_tick,
  input wire logic debug_reset_pin,
  input wire logic ram_access,
  input wire logic power_on_event,
  output logic sys_reset_n,
  output rsc_osc_ctrl_t osc_ctrl,
  output logic sys_clk_en,
  output logic [2:0] cpu_clk_div,
  output logic cpu_fetch_en,
  output logic periph_start_ok,
  output logic [WDT_W-1:0] watchdog_count,
  output logic debug_mode,
  output logic ram_intact,
  output logic irq
);

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;

  assign async_in = {power_on_event, ram_access, debug_reset_pin, int_osc_tick,
                     reset_req.wdt, reset_req.clock_monitor, reset_req.lvd};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= async_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire logic lvd_req = sync2_ff[0];
  wire logic clm_req = sync2_ff[1];
  wire logic wdt_req = sync2_ff[2];
  wire logic tick_lvl = sync2_ff[3];
  wire logic dbg_pin = sync2_ff[4];
  wire logic ram_busy = sync2_ff[5];
  wire logic por_seen = sync2_ff[6];
  wire logic any_req = lvd_req | clm_req | wdt_req;

  logic [2:0] req_prev_ff;
  logic tick_prev_ff;
  wire logic [2:0] req_rise = {wdt_req, clm_req, lvd_req} & ~req_prev_ff;
  wire logic tick_rise = tick_lvl & ~tick_prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_ff <= 3'h0;
      tick_prev_ff <= 1'b0;
    end else begin
      req_prev_ff <= {wdt_req, clm_req, lvd_req};
      tick_prev_ff <= tick_lvl;
    end
  end

  // ***************************************************************
  // reset sequencer
  // ***************************************************************
  // pin reset lands directly in the stabilisation wait
  rsc_state_t state_ff;
  rsc_state_t nxt_state;
  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;

  wire logic hold_done = cnt_ff >= TMR_W'(HOLD_CYCLES - 1);
  wire logic stab_done = cnt_ff >= TMR_W'(STAB_CYCLES - 1);

  always_comb begin
    nxt_state = state_ff;
    if (any_req) begin
      nxt_state = ST_INT_RST; // RULE_10
    end else begin
      case (state_ff)
        ST_INT_RST: if (hold_done) nxt_state = ST_STAB;
        ST_STAB: if (stab_done) nxt_state = ST_RUN; // RULE_15
        ST_RUN: nxt_state = ST_RUN;
        default: nxt_state = ST_STAB;
      endcase
    end
  end

  assign nxt_cnt = (nxt_state != state_ff || state_ff == ST_RUN) ? '0 : cnt_ff + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_STAB; // RULE_11
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ***************************************************************
  // system outputs
  // ***************************************************************
  logic sys_rst_n_ff;
  logic run_ff;
  rsc_osc_ctrl_t osc_ff;
  rsc_osc_ctrl_t nxt_osc;
  logic [WDT_W-1:0] wdt_cnt_ff;
  logic [WDT_W-1:0] nxt_wdt_cnt;
  wire logic in_rst_next = (nxt_state == ST_INT_RST);

  assign nxt_osc.main_en = ~in_rst_next; // RULE_19
  assign nxt_osc.int_en = ~in_rst_next; // RULE_19
  assign nxt_osc.sub_en = 1'b1;
  // counter advances only on internal oscillator ticks
  assign nxt_wdt_cnt = in_rst_next ? '0 : // RULE_14
                       (tick_rise & osc_ff.int_en) ? wdt_cnt_ff + 1'b1 : wdt_cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_rst_n_ff <= 1'b0; // RULE_10
      run_ff <= 1'b0;
      osc_ff <= '{main_en: 1'b0, int_en: 1'b0, sub_en: 1'b1}; // RULE_19
      wdt_cnt_ff <= '0; // RULE_14
    end else begin
      sys_rst_n_ff <= ~in_rst_next;
      run_ff <= (nxt_state == ST_RUN); // RULE_15 RULE_16
      osc_ff <= nxt_osc;
      wdt_cnt_ff <= nxt_wdt_cnt;
    end
  end

  assign sys_reset_n = sys_rst_n_ff;
  assign osc_ctrl = osc_ff;
  assign sys_clk_en = run_ff; // RULE_13
  assign cpu_fetch_en = run_ff; // RULE_15
  assign periph_start_ok = run_ff; // RULE_16
  assign watchdog_count = wdt_cnt_ff;

  // ***************************************************************
  // apb decode
  // ***************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : hit

  wire logic access = psel & penable;
  wire logic wr_en = access & pwrite;
  wire logic rd_setup = psel & ~penable & ~pwrite;
  wire logic lane0 = pstrb[0];
  wire logic mapped = hit(paddr, OFS_CAUSE) | hit(paddr, OFS_KEY) | hit(paddr, OFS_BITOP) |
                      hit(paddr, OFS_CLKCTL) | hit(paddr, OFS_DBG) |
                      hit(paddr, OFS_IRQ_STAT) | hit(paddr, OFS_IRQ_MASK) |
                      hit(paddr, OFS_STATUS);

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ***************************************************************
  // protected write sequence
  // ***************************************************************
  // the key arms exactly one following write; any other write disarms
  logic armed_ff;
  wire logic key_wr = wr_en & hit(paddr, OFS_KEY) & lane0 & (pwdata[7:0] == PROTECT_KEY);
  wire logic tgt_wr = wr_en & (hit(paddr, OFS_CAUSE) | hit(paddr, OFS_BITOP));
  wire logic cause_wr = tgt_wr & hit(paddr, OFS_CAUSE) & armed_ff & lane0; // RULE_02 RULE_03
  wire logic bitop_wr = tgt_wr & hit(paddr, OFS_BITOP) & armed_ff & lane0; // RULE_03
  wire logic prot_err = tgt_wr & ~armed_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
    end else if (wr_en) begin
      armed_ff <= key_wr; // RULE_02
    end
  end

  // ***************************************************************
  // reset cause flags
  // ***************************************************************
  logic [7:0] cause_ff;
  logic [7:0] nxt_cause;
  wire logic [7:0] set_vec = {3'h0, wdt_req, 2'h0, clm_req, lvd_req}; // RULE_04 RULE_05 RULE_06
  wire logic [7:0] byte_keep = cause_wr ? pwdata[7:0] : 8'hFF; // RULE_08
  wire logic [7:0] bit_keep = (bitop_wr & ~pwdata[BITOP_VAL_BIT]) ?
                              ~(8'h01 << pwdata[2:0]) : 8'hFF; // RULE_03
  // set after the clear mask so a coinciding source wins
  assign nxt_cause = ((cause_ff & byte_keep & bit_keep) | set_vec) & CAUSE_MASK; // RULE_07 RULE_09

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= CAUSE_RESET; // RULE_01
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  // ***************************************************************
  // clock control, debug, ram
  // ***************************************************************
  logic [2:0] div_ff;
  logic [7:0] dbg_ctrl_ff;
  logic debug_mode_ff;
  logic ram_ok_ff;
  wire logic clk_wr = wr_en & hit(paddr, OFS_CLKCTL) & lane0;
  wire logic dbg_wr = wr_en & hit(paddr, OFS_DBG) & lane0;
  wire logic ram_hit = (in_rst_next & (state_ff != ST_INT_RST) & ram_busy) | por_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= CPU_DIV8; // RULE_13
      dbg_ctrl_ff <= DBG_RESET; // RULE_12
      debug_mode_ff <= 1'b0;
      ram_ok_ff <= 1'b1;
    end else begin
      if (in_rst_next) begin
        div_ff <= CPU_DIV8; // RULE_13
      end else if (clk_wr) begin
        div_ff <= pwdata[2:0];
      end
      if (dbg_wr) begin
        dbg_ctrl_ff <= pwdata[7:0] & DBG_MASK;
      end
      if (dbg_ctrl_ff[0] & dbg_pin) begin
        debug_mode_ff <= 1'b1; // RULE_18
      end
      if (ram_hit) begin
        ram_ok_ff <= 1'b0; // RULE_17
      end
    end
  end

  assign cpu_clk_div = div_ff;
  assign debug_mode = debug_mode_ff;
  assign ram_intact = ram_ok_ff;

  // ***************************************************************
  // interrupts
  // ***************************************************************
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  wire logic [IRQ_W-1:0] irq_ev = {prot_err, req_rise[0], req_rise[1], req_rise[2]};
  wire logic [IRQ_W-1:0] irq_w1c = (wr_en & hit(paddr, OFS_IRQ_STAT) & lane0) ?
                                   pwdata[IRQ_W-1:0] : '0;
  wire logic mask_wr = wr_en & hit(paddr, OFS_IRQ_MASK) & lane0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_ev;
      if (mask_wr) begin
        irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ***************************************************************
  // read data
  // ***************************************************************
  logic [31:0] prdata_ff;
  wire logic [31:0] status_word = {wdt_cnt_ff, 12'h000, debug_mode_ff, ram_ok_ff,
                                   state_ff};
  wire logic [31:0] rd_mux =
      hit(paddr, OFS_CAUSE) ? {24'h000000, cause_ff} :
      hit(paddr, OFS_CLKCTL) ? {29'h00000000, div_ff} :
      hit(paddr, OFS_DBG) ? {24'h000000, dbg_ctrl_ff} :
      hit(paddr, OFS_IRQ_STAT) ? {28'h0000000, irq_stat_ff} :
      hit(paddr, OFS_IRQ_MASK) ? {28'h0000000, irq_mask_ff} :
      hit(paddr, OFS_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata = prdata_ff;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic first_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  sequence s_enter_rst;
    (state_ff != ST_INT_RST) ##1 (state_ff == ST_INT_RST);
  endsequence

  sequence s_stab_end;
    (state_ff == ST_STAB) && stab_done && !any_req;
  endsequence

  chk_pin_reset_val: assert property (first_ff |-> cause_ff == 8'h00 && dbg_ctrl_ff == 8'h01 // RULE_01 RULE_12
    && div_ff == CPU_DIV8) else $error("bad values after pin reset");
  chk_plain_store: assert property (tgt_wr && !armed_ff && !any_req |=> // RULE_02
    $stable(cause_ff)) else $error("unprotected write changed cause flags");
  chk_byte_lane: assert property (tgt_wr && !lane0 && !any_req |=> // RULE_03
    $stable(cause_ff)) else $error("write without lane 0 changed cause flags");
  chk_wdt_flag: assert property (wdt_req |=> cause_ff[WDT_FLAG_BIT]) // RULE_04
    else $error("watchdog flag not set");
  chk_clm_flag: assert property (clm_req |=> cause_ff[CLM_FLAG_BIT]) // RULE_05
    else $error("clock monitor flag not set");
  chk_reserved_zero: assert property ((cause_ff & ~CAUSE_MASK) == 8'h00 // RULE_06
    && ((cause_ff[LVD_FLAG_BIT] == 1'b0) || $past(lvd_req) || $past(cause_ff[0])))
    else $error("reserved or low voltage flag wrong");
  chk_own_flag: assert property (wdt_req && !clm_req && !lvd_req && !cause_wr && !bitop_wr // RULE_07
    |=> cause_ff[1:0] == $past(cause_ff[1:0])) else $error("other flag disturbed");
  chk_write_one: assert property (!any_req |=> (cause_ff & ~$past(cause_ff)) == 8'h00) // RULE_08
    else $error("software write set a flag");
  chk_set_wins: assert property (cause_wr && lvd_req && !pwdata[LVD_FLAG_BIT] |=> // RULE_09
    cause_ff[LVD_FLAG_BIT]) else $error("clear beat a coinciding set");
  chk_rst_hold: assert property (s_enter_rst |-> !sys_reset_n && !cpu_fetch_en // RULE_10 RULE_15
    && !periph_start_ok) else $error("system not held in internal reset");
  chk_stab_release: assert property (s_stab_end |=> run_ff && sys_clk_en) // RULE_11 RULE_13
    else $error("run not entered after stabilisation");
  chk_fetch_after: assert property ($rose(cpu_fetch_en) |-> $past(state_ff) == ST_STAB // RULE_15 RULE_16
    && $past(stab_done)) else $error("fetch enabled before stabilisation");
  chk_wdt_clear: assert property (!sys_reset_n |-> watchdog_count == '0) // RULE_14
    else $error("watchdog count not cleared in reset");
  chk_wdt_count: assert property (sys_reset_n && !in_rst_next && tick_rise && osc_ff.int_en
    |=> watchdog_count == $past(watchdog_count) + 1'b1) // RULE_14
    else $error("watchdog count did not advance");
  chk_ram_collide: assert property (s_enter_rst ##0 $past(ram_busy) |-> !ram_intact) // RULE_17
    else $error("ram collision not flagged");
  chk_debug_entry: assert property (dbg_ctrl_ff[0] && dbg_pin |=> debug_mode) // RULE_18
    else $error("debug mode not entered");
  chk_osc_stop: assert property ((state_ff == ST_INT_RST) |-> !osc_ctrl.main_en // RULE_19
    && !osc_ctrl.int_en && osc_ctrl.sub_en) else $error("oscillator state wrong in reset");

endmodule : rsc_top
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STAB = 8;
  localparam int LIMIT = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errf;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0] pstrb;
  logic debug_reset_pin, ram_access, power_on_event, sys_reset_n, sys_clk_en, irq;
  logic cpu_fetch_en, periph_start_ok, debug_mode, ram_intact, int_osc_tick;
  logic [2:0] cpu_clk_div;
  logic [WDT_W-1:0] watchdog_count;
  rsc_reset_req_t reset_req, fire, stretch;
  rsc_osc_ctrl_t osc_ctrl;
  int n_errors, check_count, cyc, cause_m;
  int fb[3] = '{LVD_FLAG_BIT, CLM_FLAG_BIT, WDT_FLAG_BIT};
  rsc_top #(.STAB_CYCLES(STAB), .HOLD_CYCLES(4)) rsc_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_req(reset_req),
    .int_osc_tick(int_osc_tick), .debug_reset_pin(debug_reset_pin), .ram_access(ram_access),
    .power_on_event(power_on_event), .sys_reset_n(sys_reset_n), .osc_ctrl(osc_ctrl),
    .sys_clk_en(sys_clk_en), .cpu_clk_div(cpu_clk_div), .cpu_fetch_en(cpu_fetch_en),
    .periph_start_ok(periph_start_ok), .watchdog_count(watchdog_count),
    .debug_mode(debug_mode), .ram_intact(ram_intact), .irq(irq));
  rsc_src_model rsc_src_model_i (.pclk(pclk), .presetn(presetn), .fire(fire),
    .stretch(stretch), .osc_ctrl(osc_ctrl), .reset_req(reset_req), .int_osc_tick(int_osc_tick));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // ***************************************************************
  // checking and apb tasks
  // ***************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    errf = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task prot(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, OFS_KEY, {24'h0, PROTECT_KEY});
    apb(1'b1, a, dat);
  endtask : prot
  task wait_run;
    int k;
    k = 0;
    while (cpu_fetch_en !== 1'b1 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    chk({29'h0, sys_clk_en, periph_start_ok, cpu_fetch_en}, 32'h7);
  endtask : wait_run
  task fire_src(input int b);
    int k;
    k = 0;
    @(posedge pclk);
    fire <= rsc_reset_req_t'(3'(1 << b));
    @(posedge pclk);
    fire <= '0;
    while (sys_reset_n !== 1'b0 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    chk({30'h0, cpu_fetch_en, periph_start_ok}, 32'h0);
    chk({29'h0, osc_ctrl}, 32'h1);
    chk({29'h0, cpu_clk_div}, {29'h0, CPU_DIV8});
    chk({16'h0, watchdog_count}, 32'h0);
    wait_run();
  endtask : fire_src
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      results();
    end
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {psel, penable, pwrite, debug_reset_pin, ram_access, power_on_event} = 6'h00;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    fire = '0;
    stretch = '0;
    presetn = 1'b0;
    void'($urandom(32'h2141d0bd));
    repeat (3) @(posedge pclk);
    chk({30'h0, sys_reset_n, cpu_fetch_en}, 32'h0);
    chk({29'h0, osc_ctrl}, 32'h1);
    chk({16'h0, watchdog_count}, 32'h0);
    presetn <= 1'b1;
    repeat (STAB - 1) @(posedge pclk);
    chk({31'h0, cpu_fetch_en}, 32'h0);
    wait_run();
    chk({29'h0, cpu_clk_div}, {29'h0, CPU_DIV8});
    rdchk(OFS_CAUSE, 32'h0);
    rdchk(OFS_DBG, 32'h1);
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h6);
    chk({31'h0, rd[31:16] != 16'h0}, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, errf}, 32'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_CLKCTL, 32'h0);
    cause_m = 0;
    for (int b = 0; b < 3; b++) begin
      ram_access <= (b == 1);
      fire_src(b);
      cause_m = cause_m | (1 << fb[b]);
      rdchk(OFS_CAUSE, 32'(cause_m));
    end
    ram_access <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[2]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdchk(OFS_IRQ_STAT, 32'h7);
    apb(1'b1, OFS_IRQ_MASK, 32'hF);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_CAUSE, 32'h0);
    rdchk(OFS_CAUSE, 32'(cause_m));
    apb(1'b1, OFS_KEY, {24'h0, PROTECT_KEY});
    apb(1'b1, OFS_IRQ_MASK, 32'hF);
    apb(1'b1, OFS_CAUSE, 32'h0);
    rdchk(OFS_CAUSE, 32'(cause_m));
    rdchk(OFS_IRQ_STAT, 32'hF);
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    prot(OFS_BITOP, 32'h100);
    rdchk(OFS_CAUSE, 32'(cause_m));
    prot(OFS_BITOP, 32'h001);
    cause_m = cause_m & ~2;
    rdchk(OFS_CAUSE, 32'(cause_m));
    apb(1'b1, OFS_KEY, {24'h0, PROTECT_KEY});
    pstrb <= 4'hE;
    apb(1'b1, OFS_CAUSE, 32'h0);
    pstrb <= 4'hF;
    rdchk(OFS_CAUSE, 32'(cause_m));
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      prot(OFS_CAUSE, d);
      cause_m = cause_m & int'(d[7:0]);
      rdchk(OFS_CAUSE, 32'(cause_m));
    end
    stretch <= 3'h1;
    repeat (6) @(posedge pclk);
    prot(OFS_CAUSE, 32'h0);
    rdchk(OFS_CAUSE, 32'h1);
    stretch <= '0;
    wait_run();
    apb(1'b1, OFS_DBG, 32'h0);
    debug_reset_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, debug_mode}, 32'h0);
    debug_reset_pin <= 1'b0;
    apb(1'b1, OFS_DBG, 32'h1);
    debug_reset_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, debug_mode}, 32'h1);
    debug_reset_pin <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h0, debug_mode, sys_reset_n}, 32'h0);
    presetn <= 1'b1;
    wait_run();
    rdchk(OFS_CAUSE, 32'h0);
    rdchk(OFS_DBG, 32'h1);
    chk({31'h0, ram_intact}, 32'h1);
    power_on_event <= 1'b1;
    repeat (3) @(posedge pclk);
    power_on_event <= 1'b0;
    @(posedge pclk);
    chk({31'h0, ram_intact}, 32'h0);
    results();
  end
endmodule : tb
`default_nettype wire
